// >>> common/fcc_pkg.sv
package fcc_pkg;
  // ---------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned NS_PER_MS     = 1000000;
  localparam int unsigned CYC_PER_MS    = NS_PER_MS / CLK_PERIOD_NS;
  // Least time the request pin stays low before a new charge cycle
  localparam int unsigned REQ_LOW_NS    = 10000;
  localparam int unsigned REQ_LOW_CYC   = (REQ_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Default longest designed charge time
  localparam int unsigned MAX_CHARGE_MS = 5000;
  localparam int unsigned TIMER_W       = 32;
  localparam logic [TIMER_W-1:0] TIMER_ZERO = '0;
  localparam logic [TIMER_W-1:0] TIMER_ONE  = 32'h0000_0001;

  // ---------------------------------------------------------------
  // Controller states
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    FCC_IDLE     = 3'b000,
    FCC_CHARGING = 3'b001,
    FCC_DONE     = 3'b010,
    FCC_FAULT    = 3'b011,
    FCC_RELEASE  = 3'b100
  } fcc_state_e;
endpackage

// >>> core/fcc_host.sv
`timescale 1ns/1ps
// Function
// - After a forced stop the host may raise the request again for a new cycle.
// - Host times request-to-done; too long means an overcurrent fault.
// - Thermal recovery needs trip cleared and the host dropping the request.
// - Overcurrent recovery needs the host dropping the request after the trip.
module fcc_host #(
  parameter logic [31:0] MAX_CHARGE_CYC = fcc_pkg::MAX_CHARGE_MS * fcc_pkg::CYC_PER_MS
) (
  // Clock and reset
  input  wire logic MCLK,
  input  wire logic RESETN,
  // User commands
  input  wire logic START,
  input  wire logic STOP,
  input  wire logic FLASH_ARM,
  input  wire logic FLASH_FIRE,
  // User status
  output logic      BUSY,
  output logic      DONE,
  output logic      FAULT_TIMEOUT,
  // Device pins
  output logic      CHARGE_REQUEST,
  output logic      FLASH_PERMIT,
  output logic      FLASH_TRIGGER,
  input  wire logic CHARGE_DONE_N
);

  // ---------------------------------------------------------------
  // State and timers
  // ---------------------------------------------------------------
  fcc_pkg::fcc_state_e          state;
  fcc_pkg::fcc_state_e          next_state;
  logic [fcc_pkg::TIMER_W-1:0]  timer;
  logic [fcc_pkg::TIMER_W-1:0]  next_timer;
  logic                         next_fault;

  // Decoded conditions
  wire logic done_seen  = ~CHARGE_DONE_N;
  wire logic timed_out  = (timer >= MAX_CHARGE_CYC);
  wire logic low_served = (timer >= (fcc_pkg::REQ_LOW_CYC - 1));
  wire logic timer_inc  = (state == fcc_pkg::FCC_CHARGING) || (state == fcc_pkg::FCC_RELEASE)
                          || (state == fcc_pkg::FCC_FAULT);
  wire logic timer_clr  = (next_state != state);

  // Next-state decode; the request output follows the state
  always_comb begin
    next_state = state;
    case (state)
      fcc_pkg::FCC_IDLE: begin
        if (START) begin
          next_state = fcc_pkg::FCC_CHARGING;
        end
      end
      fcc_pkg::FCC_CHARGING: begin
        if (STOP) begin
          next_state = fcc_pkg::FCC_RELEASE;        // Forced stop
        end else if (done_seen) begin
          next_state = fcc_pkg::FCC_DONE;
        end else if (timed_out) begin
          next_state = fcc_pkg::FCC_FAULT;          // Overlong charge
        end
      end
      fcc_pkg::FCC_DONE: begin
        if (STOP) begin
          next_state = fcc_pkg::FCC_RELEASE;        // Only a stop clears done and drops the request
        end
      end
      fcc_pkg::FCC_FAULT: begin
        if (low_served) begin
          next_state = fcc_pkg::FCC_IDLE;           // Request held low to rearm
        end
      end
      fcc_pkg::FCC_RELEASE: begin
        if (low_served) begin
          next_state = fcc_pkg::FCC_IDLE;
        end
      end
      default: begin
        next_state = fcc_pkg::FCC_IDLE;
      end
    endcase
  end

  // Timer counts time in charging and the low hold; restarts on every state change
  assign next_timer = timer_clr ? fcc_pkg::TIMER_ZERO
                    : (timer_inc ? timer + fcc_pkg::TIMER_ONE : timer);

  // Timeout flag is sticky until the next charge is started
  assign next_fault = (next_state == fcc_pkg::FCC_FAULT) ? 1'b1
                    : ((state == fcc_pkg::FCC_IDLE) && START) ? 1'b0 : FAULT_TIMEOUT;

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  // State, timer and fault flag
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      state         <= fcc_pkg::FCC_IDLE;
      timer         <= fcc_pkg::TIMER_ZERO;
      FAULT_TIMEOUT <= 1'b0;
    end else begin
      state         <= next_state;
      timer         <= next_timer;
      FAULT_TIMEOUT <= next_fault;
    end
  end

  // Pin and status outputs come straight from flip-flops
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      CHARGE_REQUEST <= 1'b0;
      BUSY           <= 1'b0;
      DONE           <= 1'b0;
      FLASH_PERMIT   <= 1'b0;
      FLASH_TRIGGER  <= 1'b0;
    end else begin
      // Request high only in charging and done; a fault drops it at once
      CHARGE_REQUEST <= (next_state == fcc_pkg::FCC_CHARGING)
                        || (next_state == fcc_pkg::FCC_DONE);
      BUSY           <= (next_state != fcc_pkg::FCC_IDLE) && (next_state != fcc_pkg::FCC_DONE);
      DONE           <= (next_state == fcc_pkg::FCC_DONE);
      // Trigger is gated by arm so the gate cannot fire on a stray trigger
      FLASH_PERMIT   <= FLASH_ARM;
      FLASH_TRIGGER  <= FLASH_ARM & FLASH_FIRE;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  sequence s_timeout_hit;
    (state == fcc_pkg::FCC_CHARGING) && !STOP && CHARGE_DONE_N && timed_out;
  endsequence

  sequence s_fault_entered;
    !CHARGE_REQUEST && FAULT_TIMEOUT;
  endsequence

  AST_TIMEOUT_DROPS_REQUEST: assert property (
    @(posedge MCLK) disable iff (!RESETN)
    s_timeout_hit |=> s_fault_entered
  ) else $error("Charge timeout did not drop request and flag fault");

  AST_FAULT_HOLDS_LOW: assert property (
    @(posedge MCLK) disable iff (!RESETN)
    $rose(FAULT_TIMEOUT) |-> !CHARGE_REQUEST [*8]
  ) else $error("Request raised too soon after fault");

  AST_RESTART_AFTER_STOP: assert property (
    @(posedge MCLK) disable iff (!RESETN)
    (state == fcc_pkg::FCC_IDLE) && START |=> CHARGE_REQUEST && BUSY
  ) else $error("Start did not raise the charge request");

  AST_THERMAL_RELEASE: assert property (
    @(posedge MCLK) disable iff (!RESETN)
    $fell(CHARGE_REQUEST) |-> !CHARGE_REQUEST [*8]
  ) else $error("Request low time too short for recovery");

  AST_DONE_NEEDS_LINE: assert property (
    @(posedge MCLK) disable iff (!RESETN)
    $rose(DONE) |-> $past(CHARGE_DONE_N) == 1'b0 && CHARGE_REQUEST
  ) else $error("Done shown without the charge-done line");

  // Done is only released by a stop, which drops the request
  AST_DONE_HOLDS: assert property (
    @(posedge MCLK) disable iff (!RESETN)
    DONE && !STOP |=> DONE && CHARGE_REQUEST
  ) else $error("Done dropped without a stop");

  // While done the host is not busy and keeps the request high
  AST_DONE_NOT_BUSY: assert property (
    @(posedge MCLK) disable iff (!RESETN)
    DONE |-> !BUSY && CHARGE_REQUEST
  ) else $error("Done shown while busy or with the request low");

  // The trigger pin never rises without the permit pin
  AST_FLASH_NEEDS_PERMIT: assert property (
    @(posedge MCLK) disable iff (!RESETN)
    FLASH_TRIGGER |-> FLASH_PERMIT
  ) else $error("Flash trigger shown without permit");

endmodule

// >>> verification/fcc_dev.sv
`timescale 1ns/1ps
// ----------------
// Device model
// ----------------
module fcc_dev #(
  parameter int ENA_DLY = 500
) (
  // Pins and comparator results
  input  wire logic clk,
  input  wire logic charge_request,
  input  wire logic flash_permit,
  input  wire logic flash_trigger,
  input  wire logic full_hit,
  input  wire logic trip,
  output wire logic charge_done_n,
  output wire logic flash_gate_drive
);
  int   dly   = 0;
  logic ena   = 1'b0;
  logic done  = 1'b0;
  logic fault = 1'b0;
  // Only a low request clears a latched trip
  always @(posedge clk) begin
    if (!charge_request) begin
      dly   <= 0;
      ena   <= 1'b0;
      done  <= 1'b0;
      fault <= trip;
    end else if (trip || fault) begin
      fault <= 1'b1;
      ena   <= 1'b0;
    end else if (!done) begin
      dly  <= dly + 1;
      ena  <= (ena & !full_hit) | (dly == ENA_DLY);
      done <= ena & full_hit;
    end
  end
  // Released line reads high through the pull-up
  assign charge_done_n    = (done & !fault) ? 1'b0 : 1'b1;
  assign flash_gate_drive = flash_permit & flash_trigger;
endmodule

// >>> verification/tb.sv
`timescale 1ns/1ps
// ----------------
// Host bench
// ----------------
module tb;
  logic MCLK, RESETN, START, STOP, FLASH_ARM, FLASH_FIRE, full_hit, trip;
  logic BUSY, DONE, FAULT_TIMEOUT, CHARGE_REQUEST, FLASH_PERMIT, FLASH_TRIGGER;
  wire  CHARGE_DONE_N, gate;
  int   n_mismatch = 0, check_count = 0, seed = 70031, d;
  int   plan[4] = '{0, 1, 2, 0}; // Full, host stop, trip, fresh charge
  fcc_host #(.MAX_CHARGE_CYC(32'h0000_0800)) uut (.MCLK(MCLK), .RESETN(RESETN),
    .START(START), .STOP(STOP), .FLASH_ARM(FLASH_ARM), .FLASH_FIRE(FLASH_FIRE), .BUSY(BUSY),
    .DONE(DONE), .FAULT_TIMEOUT(FAULT_TIMEOUT), .CHARGE_REQUEST(CHARGE_REQUEST),
    .FLASH_PERMIT(FLASH_PERMIT), .FLASH_TRIGGER(FLASH_TRIGGER), .CHARGE_DONE_N(CHARGE_DONE_N));
  fcc_dev dev (.clk(MCLK), .charge_request(CHARGE_REQUEST), .flash_permit(FLASH_PERMIT),
    .flash_trigger(FLASH_TRIGGER), .full_hit(full_hit), .trip(trip),
    .charge_done_n(CHARGE_DONE_N), .flash_gate_drive(gate));
  // Free-running clock
  initial begin
    MCLK = 1'b0;
    forever #50 MCLK = ~MCLK;
  end
  function automatic int rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed & 255;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Bounded wait: 0 done, 1 idle, 2 timeout flag
  task automatic wait_on(input int sel, input int lim);
    int i;
    for (i = 0; i < lim; i++) begin
      @(negedge MCLK);
      if (sel == 0 ? DONE === 1'b1 : sel == 1 ? BUSY === 1'b0 : FAULT_TIMEOUT === 1'b1)
        break;
    end
    if (i == lim) begin
      n_mismatch++;
      complete_run();
    end
  endtask
  task automatic pulse(input logic stop_cmd);
    @(posedge MCLK);
    START <= !stop_cmd;
    STOP  <= stop_cmd;
    @(posedge MCLK);
    START <= 1'b0;
    STOP  <= 1'b0;
  endtask
  // Main sequence
  initial begin
    {RESETN, START, STOP, FLASH_ARM, FLASH_FIRE, full_hit, trip} = '0;
    repeat (10) @(posedge MCLK);
    RESETN <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      @(posedge MCLK);
      {FLASH_ARM, FLASH_FIRE} <= k[1:0];
      @(negedge MCLK);
      @(negedge MCLK);
      check(gate, k == 3);
    end
    foreach (plan[j]) begin
      pulse(1'b0);
      @(negedge MCLK);
      check(CHARGE_REQUEST, 1);
      check(FAULT_TIMEOUT, 0);
      d = 600 + rnd() % 40;
      repeat (d) @(posedge MCLK);
      full_hit <= plan[j] != 1;
      trip     <= plan[j] == 2;
      if (plan[j] == 2) begin
        @(posedge MCLK);
        trip <= 1'b0;
        wait_on(2, 2000);
        check(CHARGE_DONE_N, 1);
        check(FAULT_TIMEOUT, 1);
        check(CHARGE_REQUEST, 0);
      end else if (plan[j] == 0) begin
        wait_on(0, 20);
        check(CHARGE_DONE_N, 0);
        repeat (d) @(negedge MCLK);
        check(CHARGE_DONE_N, 0);
      end
      @(posedge MCLK);
      full_hit <= 1'b0;
      if (plan[j] != 2)
        pulse(1'b1);
      @(negedge MCLK);
      check({CHARGE_REQUEST, DONE}, 0);
      @(negedge MCLK);
      check(CHARGE_DONE_N, 1);
      wait_on(1, 200);
    end
    complete_run();
  end
endmodule
